// ===== issr_top.sv
// interrupt shadow select, service status, proximity reload and flag/enable registers
`timescale 1ns/1ns
module issr_top (
  // clock and reset
  input  wire logic                                      clk_sys,
  input  wire logic                                      rst_n,
  // register port
  input  wire logic [issr_pkg::AW-1:0]                   reg_addr,
  input  wire logic [issr_pkg::DW-1:0]                   reg_wdata,
  input  wire logic                                      reg_we,
  input  wire logic                                      reg_re,
  output logic      [issr_pkg::DW-1:0]                   reg_rdata_q,
  // peripheral sources and their priority levels
  input  wire logic [issr_pkg::NSRC-1:0]                 src_req,
  input  wire logic [issr_pkg::NSRC*issr_pkg::LW-1:0]    src_prio,
  // cpu exception interface
  output logic                                           cpu_irq_q,
  output logic      [issr_pkg::NUM_W-1:0]                cpu_irq_num_q,
  output logic      [issr_pkg::LW-1:0]                   cpu_irq_level_q,
  output logic                                           cpu_shadow_use_q,
  output logic      [issr_pkg::LW-1:0]                   cpu_shadow_set_q,
  input  wire logic                                      cpu_ack,
  // proximity timer
  output logic                                           prox_load_q,
  output logic      [issr_pkg::DW-1:0]                   prox_reload_q,
  // block interrupt
  output logic                                           irq_q
);
  logic [issr_pkg::DW-1:0]     ctrl_q;
  logic [issr_pkg::DW-1:0]     shadow_q;
  logic [issr_pkg::LW-1:0]     lvl_stat_q;
  logic [issr_pkg::NUM_W-1:0]  srv_num_q;
  logic [issr_pkg::NSRC-1:0]   flag_q;
  logic [issr_pkg::NSRC-1:0]   en_q;
  logic [issr_pkg::NEVT-1:0]   evt_q;
  logic [issr_pkg::NEVT-1:0]   evt_en_q;
  logic [issr_pkg::NSRC-1:0]   src_lvl;
  logic [issr_pkg::NSRC-1:0]   src_prev_q;
  logic [issr_pkg::NSRC-1:0]   src_rise;
  logic [issr_pkg::NSRC-1:0]   pend;
  logic [issr_pkg::LW-1:0]     best_lvl;
  logic [issr_pkg::NUM_W-1:0]  best_num;
  logic                        multi_vector_sel;
  logic [issr_pkg::LW-1:0]     thr;
  logic                        take;
  logic                        done;
  logic                        prox_hit;
  logic                        sel_use;
  logic [issr_pkg::LW-1:0]     sel_set;
  logic [issr_pkg::SSW-1:0]    sel_code;
  logic [issr_pkg::DW-1:0]     rd_d;
  logic [issr_pkg::NEVT-1:0]   evt_set;
  issr_pkg::issr_state_t       state_q;

  // decoded write strobes
  logic wr_ctrl;
  logic wr_shadow;
  logic wr_reload;
  logic wr_flag;
  logic wr_en;
  logic wr_evt_clr;
  logic wr_evt_en;

  assign wr_ctrl    = reg_we && reg_addr == issr_pkg::OFS_CTRL;
  assign wr_shadow  = reg_we && reg_addr == issr_pkg::OFS_SHADOW;
  assign wr_reload  = reg_we && reg_addr == issr_pkg::OFS_RELOAD;
  assign wr_flag    = reg_we && reg_addr == issr_pkg::OFS_FLAG;
  assign wr_en      = reg_we && reg_addr == issr_pkg::OFS_ENABLE;
  assign wr_evt_clr = reg_we && reg_addr == issr_pkg::OFS_EVT_CLR;
  assign wr_evt_en  = reg_we && reg_addr == issr_pkg::OFS_EVT_EN;

  assign multi_vector_sel = ctrl_q[issr_pkg::CTRL_MULTI_VECTOR_SEL_BIT];
  assign thr  = ctrl_q[issr_pkg::CTRL_THR_LSB +: issr_pkg::LW];

  // source synchroniser and edge detect
  issr_sync #(
    .W (issr_pkg::NSRC)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .async_i (src_req),
    .level_o (src_lvl)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  assign src_rise = src_lvl & ~src_prev_q;

  // control and configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= issr_pkg::RST_WORD;
      shadow_q <= issr_pkg::RST_WORD;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & issr_pkg::CTRL_MASK;
      end
      if (wr_shadow) begin
        shadow_q <= reg_wdata & issr_pkg::SHADOW_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prox_reload_q <= issr_pkg::RST_WORD;
    end else if (wr_reload) begin
      prox_reload_q <= reg_wdata;
    end
  end

  // flags: a rising request wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= (wr_flag ? reg_wdata : flag_q) | src_rise;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= '0;
    end else if (wr_en) begin
      en_q <= reg_wdata;
    end
  end

  assign pend = flag_q & en_q;

  // highest level wins, ties go to the lowest source number
  always_comb begin
    best_lvl = issr_pkg::LVL_NONE;
    best_num = '0;
    for (int i = issr_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend[i] && src_prio[i*issr_pkg::LW +: issr_pkg::LW] != issr_pkg::LVL_NONE &&
          src_prio[i*issr_pkg::LW +: issr_pkg::LW] >= best_lvl) begin
        best_lvl = src_prio[i*issr_pkg::LW +: issr_pkg::LW];
        best_num = issr_pkg::NUM_W'(i);
      end
    end
  end

  // shadow set lookup for the winning level
  assign sel_code = shadow_q[{best_lvl, 2'b00} +: issr_pkg::SSW];
  always_comb begin
    sel_set = sel_code[issr_pkg::SSW-1] ? issr_pkg::SET_ZERO : sel_code[issr_pkg::LW-1:0];
    sel_use = 1'b1;
    if (!multi_vector_sel) begin
      sel_use = shadow_q[issr_pkg::SHADOW_SV_BIT];
      if (!sel_use) begin
        sel_set = issr_pkg::SET_ZERO;
      end
    end
  end

  assign take     = state_q == issr_pkg::ST_IDLE && best_lvl != issr_pkg::LVL_NONE;
  assign done     = state_q == issr_pkg::ST_PRESENT && cpu_ack;
  assign prox_hit = take && thr != issr_pkg::THR_OFF && best_lvl <= thr;

  // presentation to the cpu, held until acknowledged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= issr_pkg::ST_IDLE;
      cpu_irq_q        <= 1'b0;
      cpu_irq_num_q    <= '0;
      cpu_irq_level_q  <= issr_pkg::LVL_NONE;
      cpu_shadow_use_q <= 1'b0;
      cpu_shadow_set_q <= issr_pkg::SET_ZERO;
    end else begin
      case (state_q)
        issr_pkg::ST_IDLE: begin
          if (take) begin
            state_q          <= issr_pkg::ST_PRESENT;
            cpu_irq_q        <= 1'b1;
            cpu_irq_num_q    <= best_num;
            cpu_irq_level_q  <= best_lvl;
            cpu_shadow_use_q <= sel_use;
            cpu_shadow_set_q <= sel_set;
          end
        end
        issr_pkg::ST_PRESENT: begin
          if (cpu_ack) begin
            state_q   <= issr_pkg::ST_IDLE;
            cpu_irq_q <= 1'b0;
          end
        end
        default: begin
          state_q   <= issr_pkg::ST_IDLE;
          cpu_irq_q <= 1'b0;
        end
      endcase
    end
  end

  // service status
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_stat_q <= issr_pkg::LVL_NONE;
      srv_num_q  <= '0;
    end else begin
      if (take) begin
        lvl_stat_q <= best_lvl;
      end
      if (done) begin
        srv_num_q <= cpu_irq_num_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prox_load_q <= 1'b0;
    end else begin
      prox_load_q <= prox_hit;
    end
  end

  // block events: sticky, set wins over clear
  assign evt_set = {prox_hit, done, |src_rise};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_q    <= '0;
      evt_en_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      evt_q <= (wr_evt_clr ? evt_q & ~reg_wdata[issr_pkg::NEVT-1:0] : evt_q) | evt_set;
      if (wr_evt_en) begin
        evt_en_q <= reg_wdata[issr_pkg::NEVT-1:0];
      end
      irq_q <= |(evt_q & evt_en_q);
    end
  end

  // read mux, unmapped and write-only addresses read zero
  always_comb begin
    rd_d = issr_pkg::RST_WORD;
    case (reg_addr)
      issr_pkg::OFS_CTRL:     rd_d = ctrl_q;
      issr_pkg::OFS_SHADOW:   rd_d = shadow_q;
      issr_pkg::OFS_STATUS:   rd_d = {21'h000000, lvl_stat_q, srv_num_q};
      issr_pkg::OFS_RELOAD:   rd_d = prox_reload_q;
      issr_pkg::OFS_FLAG:     rd_d = flag_q;
      issr_pkg::OFS_ENABLE:   rd_d = en_q;
      issr_pkg::OFS_EVT_STAT: rd_d = {29'h00000000, evt_q};
      issr_pkg::OFS_EVT_EN:   rd_d = {29'h00000000, evt_en_q};
      default:                rd_d = issr_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= issr_pkg::RST_WORD;
    end else begin
      reg_rdata_q <= reg_re ? rd_d : issr_pkg::RST_WORD;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_present;
    take ##1 cpu_irq_q;
  endsequence

  sequence s_service;
    cpu_irq_q && cpu_ack ##1 !cpu_irq_q;
  endsequence

  a_shadow_direct: assert property ($rose(cpu_irq_q) && multi_vector_sel && !$past(sel_code[3])
    |-> cpu_shadow_set_q == $past(sel_code[2:0]))
    else $error("shadow set differs from level field");

  a_reserved_zero: assert property ($rose(cpu_irq_q) && $past(sel_code[3])
    |-> cpu_shadow_set_q == 3'h0)
    else $error("reserved shadow code did not give set 0");

  a_single_noset: assert property (s_present ##0 (!multi_vector_sel && !shadow_q[0])
    |-> !cpu_shadow_use_q && cpu_shadow_set_q == 3'h0)
    else $error("single vector used a shadow set while disabled");

  a_level_status: assert property ($rose(cpu_irq_q) |-> lvl_stat_q == cpu_irq_level_q)
    else $error("level status not updated on presentation");

  a_serviced_num: assert property (s_service |-> srv_num_q == $past(cpu_irq_num_q))
    else $error("serviced number not captured");

  a_reload_write: assert property (wr_reload |=> prox_reload_q == $past(reg_wdata))
    else $error("reload register did not take write");

  a_flag_set: assert property (|src_rise |=> (flag_q & $past(src_rise)) == $past(src_rise))
    else $error("request lost its flag");

  a_flag_write: assert property (wr_flag && src_rise == '0 |=> flag_q == $past(reg_wdata))
    else $error("flag write not stored");

  a_enable_gate: assert property ($rose(cpu_irq_q)
    |-> ($past(flag_q & en_q) & (32'h0000_0001 << cpu_irq_num_q[4:0])) != 32'h0000_0000)
    else $error("disabled source presented to cpu");

  a_prox_start: assert property (prox_load_q |-> $past(thr) != 3'h0 &&
    $past(best_lvl) <= $past(thr) ##1 !prox_load_q)
    else $error("proximity load without qualifying level");

  a_unmapped_zero: assert property (reg_re && reg_addr == issr_pkg::OFS_EVT_CLR
    |=> reg_rdata_q == 32'h0000_0000)
    else $error("write-only address read nonzero");

  a_hold_present: assert property (cpu_irq_q && !cpu_ack |=> cpu_irq_q && $stable(cpu_irq_num_q))
    else $error("presented request dropped before ack");
endmodule : issr_top

// ===== issr_pkg.sv
// constants and types of the interrupt shadow and status register block
package issr_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned NSRC = 32;
  localparam int unsigned LW = 3;
  localparam int unsigned SSW = 4;
  localparam int unsigned NEVT = 3;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_SHADOW = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS = 8'h20;
  localparam logic [AW-1:0] OFS_RELOAD = 8'h30;
  localparam logic [AW-1:0] OFS_FLAG = 8'h40;
  localparam logic [AW-1:0] OFS_ENABLE = 8'h50;
  localparam logic [AW-1:0] OFS_EVT_STAT = 8'h60;
  localparam logic [AW-1:0] OFS_EVT_CLR = 8'h64;
  localparam logic [AW-1:0] OFS_EVT_EN = 8'h68;

  // field positions
  localparam int unsigned CTRL_MULTI_VECTOR_SEL_BIT = 12;
  localparam int unsigned CTRL_THR_LSB = 8;
  localparam int unsigned SHADOW_SV_BIT = 0;
  localparam int unsigned SHADOW_LSB = 4;
  localparam int unsigned STAT_LVL_LSB = 8;
  localparam int unsigned NUM_W = 8;

  // writable masks, unimplemented bits stay zero
  localparam logic [DW-1:0] SHADOW_MASK = 32'hffff_fff1;
  localparam logic [DW-1:0] CTRL_MASK = 32'h0000_1700;

  // event bits
  localparam int unsigned EVT_FLAGGED = 0;
  localparam int unsigned EVT_SERVICED = 1;
  localparam int unsigned EVT_PROX = 2;

  // reset values
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [LW-1:0] LVL_NONE = 3'h0;
  localparam logic [LW-1:0] THR_OFF = 3'h0;
  localparam logic [LW-1:0] SET_ZERO = 3'h0;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PRESENT
  } issr_state_t;
endpackage : issr_pkg

// ===== issr_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module issr_sync #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // raw and filtered levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // take stage three only where stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_o <= '0;
    end else begin
      level_o <= (s3_q & ~(s2_q ^ s3_q)) | (level_o & (s2_q ^ s3_q));
    end
  end
endmodule : issr_sync

// ===== issr_cpu_model.sv
// cpu side model that acknowledges each presented request after a set wait
`timescale 1ns/1ns
module issr_cpu_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // request from the block and wait before taking it
  input  wire logic       cpu_irq_q,
  input  wire logic [7:0] ack_wait,
  // acknowledge and count of taken requests
  output logic            cpu_ack,
  output int unsigned     acks
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      acks    <= 0;
      cnt_q   <= 8'h00;
    end else if (cpu_irq_q && !cpu_ack) begin
      if (cnt_q == ack_wait) begin
        cpu_ack <= 1'b1;
        acks    <= acks + 1;
        cnt_q   <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else begin
      cpu_ack <= 1'b0;
      cnt_q   <= 8'h00;
    end
  end
endmodule : issr_cpu_model

// ===== tb.sv
// testbench of the interrupt shadow and status register block
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [31:0] reg_rdata_q;
  logic [31:0] src_req = 32'h0000_0000;
  logic [95:0] src_prio = 96'h0;
  logic        cpu_irq_q, cpu_ack, cpu_shadow_use_q, prox_load_q, irq_q;
  logic [7:0]  cpu_irq_num_q;
  logic [2:0]  cpu_irq_level_q, cpu_shadow_set_q;
  logic [31:0] prox_reload_q;
  logic [7:0]  ack_wait = 8'h04;
  int unsigned acks;
  int          err_count = 0;
  int          checks = 0;

  always #25 clk_sys = ~clk_sys;

  issr_top i_issr_top (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .src_req(src_req), .src_prio(src_prio),
    .cpu_irq_q(cpu_irq_q), .cpu_irq_num_q(cpu_irq_num_q), .cpu_irq_level_q(cpu_irq_level_q),
    .cpu_shadow_use_q(cpu_shadow_use_q), .cpu_shadow_set_q(cpu_shadow_set_q), .cpu_ack(cpu_ack),
    .prox_load_q(prox_load_q), .prox_reload_q(prox_reload_q), .irq_q(irq_q));

  issr_cpu_model i_issr_cpu_model (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_irq_q(cpu_irq_q),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack), .acks(acks));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata_q;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  task automatic s_reset;
    logic [7:0] ofs [10] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h64, 8'h68, 8'h74};
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0000_0000);
    `CHK(cpu_irq_q, 1'b0)
  endtask : s_reset

  task automatic s_regs;
    wr(8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'hffff_fff1);
    wr(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'h0000_1700);
    wr(8'h30, 32'ha5c3_0f96);
    rd_chk(8'h30, 32'ha5c3_0f96);
    wr(8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_0000);
    wr(8'h60, 32'hffff_ffff);
    rd_chk(8'h60, 32'h0000_0000);
  endtask : s_regs

  task automatic s_flag;
    @(posedge clk_sys);
    src_prio[15 +: 3] <= 3'h2;
    src_req[5]        <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd_chk(8'h40, 32'h0000_0020);
    `CHK(cpu_irq_q, 1'b0)
    wr(8'h40, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    wr(8'h40, 32'h0000_0020);
    rd_chk(8'h40, 32'h0000_0020);
  endtask : s_flag

  task automatic s_levels(input logic mv, input logic sv, input logic [2:0] thr, input logic [7:0] wt);
    logic [31:0] sh;
    logic [31:0] d;
    int unsigned n;
    sh = {31'h0, sv};
    for (int l = 1; l < 8; l++) sh[4*l +: 4] = l[0] ? l[3:0] : (4'h8 | l[3:0]);
    ack_wait <= wt;
    wr(8'h00, {19'h0, mv, 1'b0, thr, 8'h00});
    wr(8'h10, sh);
    for (int l = 1; l < 8; l++) begin
      @(posedge clk_sys);
      src_prio[15 +: 3] <= l[2:0];
      n = acks;
      wr(8'h50, 32'h0000_0020);
      for (int k = 0; k < 10 && !cpu_irq_q; k++) @(negedge clk_sys);
      `CHK(cpu_irq_q, 1'b1)
      `CHK(cpu_irq_num_q, 8'h05)
      `CHK(cpu_irq_level_q, l[2:0])
      `CHK(cpu_shadow_use_q, mv | sv)
      `CHK(cpu_shadow_set_q, (mv | sv) && l[0] ? l[2:0] : 3'h0)
      `CHK(prox_load_q, thr != 3'h0 && l <= thr)
      if (prox_load_q === 1'b1) `CHK(prox_reload_q, 32'ha5c3_0f96)
      wr(8'h50, 32'h0000_0000);
      for (int k = 0; k < 20 && acks == n; k++) @(negedge clk_sys);
      rd(8'h20, d);
      `CHK(d[7:0], 8'h05)
      if (!mv) `CHK(d, {21'h0, l[2:0], 8'h05})
    end
  endtask : s_levels

  task automatic s_events;
    rd_chk(8'h60, 32'h0000_0007);
    `CHK(irq_q, 1'b0)
    wr(8'h68, 32'h0000_0002);
    repeat (2) @(negedge clk_sys);
    `CHK(irq_q, 1'b1)
    wr(8'h64, 32'h0000_0002);
    rd_chk(8'h60, 32'h0000_0005);
    `CHK(irq_q, 1'b0)
    wr(8'h64, 32'h0000_0005);
    rd_chk(8'h60, 32'h0000_0000);
    rd_chk(8'h64, 32'h0000_0000);
  endtask : s_events

  task automatic wrap_up;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_reset();
    s_regs();
    s_flag();
    s_levels(1'b1, 1'b0, 3'h3, 8'h04);
    s_levels(1'b0, 1'b1, 3'h0, 8'h00);
    s_levels(1'b0, 1'b0, 3'h7, 8'h02);
    s_events();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule : tb
